// [dscir_top.sv]
// Serial module configuration, interrupt level/vector and mode-one registers
`timescale 1ns/100ps
// Overview of operation
// - Config register supervisor only, survives soft reset
// - Halted: other registers give bus error
// - Halt bit gates all clocks but bus
// - Freeze select: upper bit enables freezing
// - Channels freeze independently; break transmitter continues
// - Select bit picks cts sample clock
// - Privilege bit restricts switchable registers
// - Arbitration priority zero stays out
// - Level drives request; zero means none
// - Mode one registers reset zero, supervisor-only access while privilege bit set
// - Flow control negates rts on a start bit when full
// - Without flow control rts follows port
// - Rts control on both ends disables it
// - Ready select chooses full or received
// - Error mode accumulates or shows top
// - Parity mode field decodes parity kinds
// - Length field selects five to eight
module dscir_top
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  // Register bus
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic [11:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_supervisor,
  output logic [7:0] bus_rdata,
  output logic bus_ack,
  output logic bus_error,
  // Interrupt acknowledge
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire logic [3:0] iack_competitor,
  output logic [6:0] irq_request_n,
  output logic iack_won,
  output logic [7:0] iack_vector,
  // Debug and clocks
  input wire logic freeze_req,
  input wire logic module_irq,
  output logic module_clk_en,
  output logic cts_sample_clock_select,
  // Channel status inputs, index 0 is channel A
  input wire logic [1:0] rx_start_bit,
  input wire logic [1:0] at_char_boundary,
  input wire logic [1:0] tx_break,
  input wire logic [1:0] fifo_full,
  input wire logic [1:0] char_ready,
  input wire logic [1:0] top_break,
  input wire logic [1:0] top_frame,
  input wire logic [1:0] top_parity,
  input wire logic [1:0] top_pop,
  input wire logic [1:0] err_reset,
  input wire logic [1:0] output_port_bits,
  input wire logic [1:0] tx_rts_ctrl,
  // Channel results
  output logic [1:0] rts_n,
  output logic [1:0] chan_frozen,
  output logic [1:0] irq_status_bits,
  output logic [5:0] status_err_a,
  output logic [5:0] status_err_b,
  output dscir_pkg::dscir_parity_t parity_mode_a,
  output dscir_pkg::dscir_parity_t parity_mode_b,
  output logic [3:0] data_bits_a,
  output logic [3:0] data_bits_b
);
  import dscir_pkg::*;

  dscir_chan_if ch_a();
  dscir_chan_if ch_b();

  logic [15:0] module_config;
  logic [7:0] irq_priority_level_reg;
  logic [7:0] irq_vector_number;
  logic [7:0] chan_a_mode_one;
  logic [7:0] chan_b_mode_one;
  logic [15:0] next_config;
  logic [7:0] next_level;
  logic [7:0] next_vector;
  logic [7:0] next_mode_a;
  logic [7:0] next_mode_b;
  logic [7:0] next_rdata;
  logic next_ack;
  logic next_error;
  logic [6:0] next_irq_n;
  logic next_won;
  logic [7:0] next_ivec;
  logic [5:0] next_err_a;
  logic [5:0] next_err_b;
  logic halted;
  logic cfg_hit;
  logic perm_hit;
  logic switch_hit;
  logic in_map;
  logic allowed;

  // Mode-one bits to data bit count
  function automatic logic [3:0] char_bits(input logic [7:0] mode);
    char_bits = 4'h5 + {2'h0, mode[1:0]};
  endfunction

  // Status bits shown for one channel: accumulated or top of fifo
  function automatic logic [2:0] err_view(input logic [7:0] mode, input logic [2:0] sticky,
    input logic [2:0] top);
    err_view = mode[MODE_ERR_BIT] ? sticky : top;
  endfunction

  assign halted = module_config[HALT_BIT];
  assign cfg_hit = (bus_addr == OFF_CFG_HI) || (bus_addr == OFF_CFG_LO);
  assign perm_hit = (bus_addr >= OFF_CFG_HI) && (bus_addr < OFF_MODE_A);
  assign switch_hit = (bus_addr >= OFF_MODE_A) && (bus_addr <= OFF_LAST);
  assign in_map = perm_hit || switch_hit;
  assign allowed = perm_hit ? bus_supervisor : (bus_supervisor || !module_config[PRIV_BIT]);

  assign ch_a.mode = chan_a_mode_one;
  assign ch_b.mode = chan_b_mode_one;
  assign ch_a.fifo_full = fifo_full[0];
  assign ch_b.fifo_full = fifo_full[1];
  assign ch_a.char_ready = char_ready[0];
  assign ch_b.char_ready = char_ready[1];
  assign ch_a.top_break = top_break[0];
  assign ch_b.top_break = top_break[1];
  assign ch_a.top_frame = top_frame[0];
  assign ch_b.top_frame = top_frame[1];
  assign ch_a.top_parity = top_parity[0];
  assign ch_b.top_parity = top_parity[1];
  assign ch_a.top_pop = top_pop[0];
  assign ch_b.top_pop = top_pop[1];
  assign ch_a.err_reset = err_reset[0];
  assign ch_b.err_reset = err_reset[1];

  // freeze only when upper select bit set
  dscir_chan u_chan_a
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .soft_reset(soft_reset),
    .ch(ch_a),
    .freeze_req(freeze_req && module_config[FRZ_HI_BIT]),
    .rx_start_bit(rx_start_bit[0] && !halted),
    .at_char_boundary(at_char_boundary[0]),
    .tx_break(tx_break[0]),
    .out_port_bit(output_port_bits[0]),
    .tx_rts_ctrl(tx_rts_ctrl[0])
  );

  dscir_chan u_chan_b
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .soft_reset(soft_reset),
    .ch(ch_b),
    .freeze_req(freeze_req && module_config[FRZ_HI_BIT]),
    .rx_start_bit(rx_start_bit[1] && !halted),
    .at_char_boundary(at_char_boundary[1]),
    .tx_break(tx_break[1]),
    .out_port_bit(output_port_bits[1]),
    .tx_rts_ctrl(tx_rts_ctrl[1])
  );

  always_comb
  begin
    next_config = module_config;
    next_level = irq_priority_level_reg;
    next_vector = irq_vector_number;
    next_mode_a = chan_a_mode_one;
    next_mode_b = chan_b_mode_one;
    next_rdata = 8'h00;
    next_ack = 1'b0;
    next_error = 1'b0;
    if (bus_sel)
    begin
      if ((halted && !cfg_hit) || (in_map && !allowed))
        next_error = 1'b1;
      else
      begin
        next_ack = 1'b1;
        if (bus_write)
        begin
          if (bus_addr == OFF_CFG_HI)
            next_config[15:8] = bus_wdata & CFG_WMASK[15:8];
          if (bus_addr == OFF_CFG_LO)
            next_config[7:0] = bus_wdata & CFG_WMASK[7:0];
          if (bus_addr == OFF_LEVEL)
            next_level = bus_wdata & LEVEL_WMASK;
          if (bus_addr == OFF_VECTOR)
            next_vector = bus_wdata;
          if (bus_addr == OFF_MODE_A)
            next_mode_a = bus_wdata;
          if (bus_addr == OFF_MODE_B)
            next_mode_b = bus_wdata;
        end
        else
        begin
          // Unlisted locations read zero
          unique case (bus_addr)
            OFF_CFG_HI: next_rdata = module_config[15:8];
            OFF_CFG_LO: next_rdata = module_config[7:0];
            OFF_LEVEL: next_rdata = irq_priority_level_reg;
            OFF_VECTOR: next_rdata = irq_vector_number;
            OFF_MODE_A: next_rdata = chan_a_mode_one;
            OFF_MODE_B: next_rdata = chan_b_mode_one;
            default: next_rdata = 8'h00;
          endcase
        end
      end
    end
    next_irq_n = 7'h7F;
    if (module_irq && !halted && irq_priority_level_reg[2:0] != 3'h0)
      next_irq_n[irq_priority_level_reg[2:0] - 3'h1] = 1'b0;
    next_won = iack_req && module_irq && !halted && module_config[3:0] != 4'h0
      && iack_level == irq_priority_level_reg[2:0] && module_config[3:0] > iack_competitor;
    next_ivec = next_won ? irq_vector_number : 8'h00;
    next_err_a = {3'h0, err_view(chan_a_mode_one, ch_a.sticky_err, {top_break[0], top_frame[0], top_parity[0]})};
    next_err_b = {3'h0, err_view(chan_b_mode_one, ch_b.sticky_err, {top_break[1], top_frame[1], top_parity[1]})};
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      module_config <= CFG_RESET;
      irq_priority_level_reg <= LEVEL_RESET;
      irq_vector_number <= VECTOR_RESET;
      chan_a_mode_one <= MODE_RESET;
      chan_b_mode_one <= MODE_RESET;
      bus_rdata <= 8'h00;
      bus_ack <= 1'b0;
      bus_error <= 1'b0;
      irq_request_n <= 7'h7F;
      iack_won <= 1'b0;
      iack_vector <= 8'h00;
      status_err_a <= 6'h00;
      status_err_b <= 6'h00;
    end
    else if (soft_reset)
    begin
      irq_priority_level_reg <= LEVEL_RESET;
      irq_vector_number <= VECTOR_RESET;
      chan_a_mode_one <= MODE_RESET;
      chan_b_mode_one <= MODE_RESET;
      bus_rdata <= 8'h00;
      bus_ack <= 1'b0;
      bus_error <= 1'b0;
      irq_request_n <= 7'h7F;
      iack_won <= 1'b0;
      iack_vector <= 8'h00;
      status_err_a <= 6'h00;
      status_err_b <= 6'h00;
    end
    else
    begin
      module_config <= next_config;
      irq_priority_level_reg <= next_level;
      irq_vector_number <= next_vector;
      chan_a_mode_one <= next_mode_a;
      chan_b_mode_one <= next_mode_b;
      bus_rdata <= next_rdata;
      bus_ack <= next_ack;
      bus_error <= next_error;
      irq_request_n <= next_irq_n;
      iack_won <= next_won;
      iack_vector <= next_ivec;
      status_err_a <= next_err_a;
      status_err_b <= next_err_b;
    end
  end

  // Registered copies of configuration fields, so outputs come from flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      module_clk_en <= 1'b1;
      cts_sample_clock_select <= 1'b0;
      parity_mode_a <= DSCIR_PAR_WITH;
      parity_mode_b <= DSCIR_PAR_WITH;
      data_bits_a <= 4'h5;
      data_bits_b <= 4'h5;
    end
    else
    begin
      // halt gates every clock but bus
      module_clk_en <= !next_config[HALT_BIT];
      cts_sample_clock_select <= next_config[CTS_CLK_BIT];
      parity_mode_a <= dscir_parity_t'(next_mode_a[4:3]);
      parity_mode_b <= dscir_parity_t'(next_mode_b[4:3]);
      data_bits_a <= char_bits(next_mode_a);
      data_bits_b <= char_bits(next_mode_b);
    end
  end

  assign rts_n = {ch_b.rts_n, ch_a.rts_n};
  assign chan_frozen = {ch_b.frozen, ch_a.frozen};
  assign irq_status_bits = {ch_b.ready_irq, ch_a.ready_irq};
endmodule

// [dscir_pkg.sv]
// Package: offsets, fields, reset values and enums for the serial config block
package dscir_pkg;
  localparam logic [11:0] OFF_CFG_HI = 12'h700;
  localparam logic [11:0] OFF_CFG_LO = 12'h701;
  localparam logic [11:0] OFF_LEVEL = 12'h704;
  localparam logic [11:0] OFF_VECTOR = 12'h705;
  localparam logic [11:0] OFF_MODE_A = 12'h710;
  localparam logic [11:0] OFF_MODE_B = 12'h718;
  localparam logic [11:0] OFF_LAST = 12'h721;
  localparam int HALT_BIT = 15;
  localparam int FRZ_HI_BIT = 14;
  localparam int FRZ_LO_BIT = 13;
  localparam int CTS_CLK_BIT = 12;
  localparam int PRIV_BIT = 7;
  localparam logic [15:0] CFG_RESET = 16'h0080;
  localparam logic [15:0] CFG_WMASK = 16'hF08F;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] LEVEL_WMASK = 8'h07;
  localparam logic [7:0] VECTOR_RESET = 8'h0F;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int MODE_FLOW_BIT = 7;
  localparam int MODE_RDYSEL_BIT = 6;
  localparam int MODE_ERR_BIT = 5;
  localparam int MODE_PTYPE_BIT = 2;
  typedef enum logic [1:0] {DSCIR_PAR_WITH, DSCIR_PAR_FORCE, DSCIR_PAR_NONE, DSCIR_PAR_MULTI} dscir_parity_t;
  typedef enum {DSCIR_IDLE, DSCIR_ANSWER} dscir_bus_state_t;
endpackage

// [dscir_chan_if.sv]
// Interface carrying one channel's mode settings and status between modules
`timescale 1ns/100ps
interface dscir_chan_if;
  logic [7:0] mode;
  logic fifo_full;
  logic char_ready;
  logic top_break;
  logic top_frame;
  logic top_parity;
  logic top_pop;
  logic err_reset;
  logic frozen;
  logic rts_n;
  logic ready_irq;
  logic [2:0] sticky_err;
  modport cfg (output mode, output err_reset, input frozen, input rts_n, input ready_irq, input sticky_err,
    input fifo_full, input char_ready, input top_break, input top_frame, input top_parity, input top_pop);
  modport chan (input mode, input err_reset, output frozen, output rts_n, output ready_irq, output sticky_err,
    input fifo_full, input char_ready, input top_break, input top_frame, input top_parity, input top_pop);
endinterface

// [dscir_chan.sv]
// Per-channel control: flow control, ready select, error accumulation, freeze
`timescale 1ns/100ps
module dscir_chan
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  // Channel link
  dscir_chan_if.chan ch,
  // Channel environment
  input wire logic freeze_req,
  input wire logic rx_start_bit,
  input wire logic at_char_boundary,
  input wire logic tx_break,
  input wire logic out_port_bit,
  input wire logic tx_rts_ctrl
);
  import dscir_pkg::*;
  logic [2:0] next_sticky;
  logic next_rts_n;
  logic next_frozen;
  logic next_ready;
  always_comb
  begin
    next_sticky = ch.sticky_err;
    if (ch.err_reset)
      next_sticky = 3'h0;
    if (ch.top_pop)
      next_sticky = next_sticky | {ch.top_break, ch.top_frame, ch.top_parity};
    next_rts_n = ch.rts_n;
    if (ch.mode[MODE_FLOW_BIT] && tx_rts_ctrl)
      next_rts_n = ~out_port_bit;
    else if (ch.mode[MODE_FLOW_BIT])
    begin
      if (rx_start_bit && ch.fifo_full)
        next_rts_n = 1'b1;
      else if (!ch.fifo_full)
        next_rts_n = 1'b0;
    end
    else
      next_rts_n = ~out_port_bit;
    next_frozen = ch.frozen;
    // freeze at boundary, not in break
    if (!freeze_req)
      next_frozen = 1'b0;
    else if (at_char_boundary && !tx_break)
      next_frozen = 1'b1;
    next_ready = ch.mode[MODE_RDYSEL_BIT] ? ch.fifo_full : ch.char_ready;
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ch.sticky_err <= 3'h0;
      ch.rts_n <= 1'b1;
      ch.frozen <= 1'b0;
      ch.ready_irq <= 1'b0;
    end
    else if (soft_reset)
    begin
      ch.sticky_err <= 3'h0;
      ch.rts_n <= 1'b1;
      ch.frozen <= 1'b0;
      ch.ready_irq <= 1'b0;
    end
    else
    begin
      ch.sticky_err <= next_sticky;
      ch.rts_n <= next_rts_n;
      ch.frozen <= next_frozen;
      ch.ready_irq <= next_ready;
    end
  end
endmodule

// [dscir_top_monitor.sv]
// Port-level checks for the serial config block
`timescale 1ns/100ps
module dscir_monitor
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic bus_sel,
  input wire logic [11:0] bus_addr,
  input wire logic bus_supervisor,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic bus_error,
  // Channel and interrupt results
  input wire logic freeze_req,
  input wire logic [1:0] fifo_full,
  input wire logic [1:0] output_port_bits,
  input wire logic [1:0] rts_n,
  input wire logic [1:0] chan_frozen,
  input wire logic [6:0] irq_request_n,
  input wire logic iack_won,
  input wire logic [7:0] iack_vector,
  input wire logic [3:0] data_bits_a,
  input wire logic [5:0] status_err_a
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  one_answer_a: assert property (bus_sel |=> bus_ack != bus_error)
    else $error("access not answered exactly once");
  idle_quiet_a: assert property (!bus_sel |=> !bus_ack && !bus_error)
    else $error("answer without access");
  rdata_idle_a: assert property (!bus_ack |-> bus_rdata == 8'h00)
    else $error("read data outside answer");
  user_block_a: assert property (bus_sel && !bus_supervisor && bus_addr[11:4] == 8'h70 |=> bus_error)
    else $error("user access to supervisor space");
  vector_gate_a: assert property (!iack_won |-> iack_vector == 8'h00)
    else $error("vector given without win");
  one_level_a: assert property ($countones(~irq_request_n) <= 1)
    else $error("several request lines low");
  freeze_off_a: assert property (!freeze_req |=> chan_frozen == 2'h0)
    else $error("frozen without freeze request");
  rts_follow_a: assert property (!fifo_full[0] && output_port_bits[0] |=> !rts_n[0])
    else $error("rts not asserted");
  length_range_a: assert property (data_bits_a inside {[4'h5:4'h8]})
    else $error("data bits out of range");
  err_upper_a: assert property (status_err_a[5:3] == 3'h0)
    else $error("error status upper bits set");
  cover property (bus_error);
  cover property (iack_won);
  cover property (chan_frozen[0]);
endmodule

// [dscir_cpu_model.sv]
// Processor-side bus master model for byte accesses
`timescale 1ns/100ps
module dscir_cpu_model
(
  // Clock
  input wire logic ref_clk,
  // Requests
  output logic bus_sel,
  output logic bus_write,
  output logic [11:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_supervisor,
  // Answers
  input wire logic [7:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic bus_error
);
  initial
  begin
    {bus_sel, bus_write, bus_addr, bus_wdata, bus_supervisor} = '0;
  end
  // Request held for up to four edges until an answer is sampled; no answer leaves ae at zero
  task automatic xfer(input logic [1:0] ws, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] rd, output logic [1:0] ae);
    int n;
    @(posedge ref_clk);
    #5;
    bus_sel = 1'h1;
    bus_write = ws[1];
    bus_supervisor = ws[0];
    bus_addr = a;
    bus_wdata = d;
    rd = 8'h00;
    ae = 2'h0;
    for (n = 0; n < 4 && ae == 2'h0; n++)
    begin
      @(posedge ref_clk);
      if (bus_ack || bus_error)
      begin
        rd = bus_rdata;
        ae = {bus_ack, bus_error};
      end
    end
    #5;
    // Released lines other than supervisor must not keep the old value
    bus_sel = 1'h0;
    bus_write = ~ws[1];
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
endmodule

// [dual_serial_config_irq_regs_tb.sv]
// Self-checking bench for the serial config block
`timescale 1ns/100ps
module dual_serial_config_irq_regs_tb;
  import dscir_pkg::*;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic soft_reset = 1'h0;
  logic bus_sel, bus_write, bus_supervisor, bus_ack, bus_error;
  logic [11:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, iack_vector, rd;
  logic iack_req, module_irq, freeze_req, iack_won, module_clk_en, cts_sample_clock_select;
  logic [2:0] iack_level;
  logic [3:0] iack_competitor, data_bits_a, data_bits_b;
  logic [1:0] rx_start_bit, at_char_boundary, tx_break, fifo_full, char_ready, top_break, top_frame;
  logic [1:0] top_parity, top_pop, err_reset, output_port_bits, tx_rts_ctrl, rts_n, chan_frozen;
  logic [1:0] irq_status_bits, ae;
  logic [6:0] irq_request_n;
  logic [5:0] status_err_a, status_err_b;
  dscir_parity_t parity_mode_a, parity_mode_b;
  int err_count = 0;
  int cmp_count = 0;
  // Rows: write, address, write data, read data, error expected
  logic [29:0] rows [17] = '{
    {1'h0, OFF_CFG_HI, 8'h00, 8'h00, 1'h0}, {1'h0, OFF_CFG_LO, 8'h00, 8'h80, 1'h0},
    {1'h0, OFF_LEVEL, 8'h00, 8'h00, 1'h0}, {1'h0, OFF_VECTOR, 8'h00, 8'h0F, 1'h0},
    {1'h0, OFF_MODE_A, 8'h00, 8'h00, 1'h0}, {1'h0, OFF_MODE_B, 8'h00, 8'h00, 1'h0},
    {1'h1, OFF_CFG_LO, 8'hFF, 8'h00, 1'h0}, {1'h0, OFF_CFG_LO, 8'h00, 8'h8F, 1'h0},
    {1'h1, OFF_CFG_HI, 8'h7F, 8'h00, 1'h0}, {1'h0, OFF_CFG_HI, 8'h00, 8'h70, 1'h0},
    {1'h1, OFF_LEVEL, 8'hFF, 8'h00, 1'h0}, {1'h0, OFF_LEVEL, 8'h00, 8'h07, 1'h0},
    {1'h1, OFF_VECTOR, 8'hA5, 8'h00, 1'h0}, {1'h0, OFF_VECTOR, 8'h00, 8'hA5, 1'h0},
    {1'h1, OFF_MODE_B, 8'h3C, 8'h00, 1'h0}, {1'h0, OFF_MODE_B, 8'h00, 8'h3C, 1'h0},
    {1'h0, 12'h730, 8'h00, 8'h00, 1'h0}};
  always #25 ref_clk = ~ref_clk;
  dscir_top dut_u (.*);
  dscir_cpu_model cpu_u (.*);
  task summarize;
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task acc(input logic [1:0] ws, input logic [11:0] a, input logic [7:0] d, exp, input logic [1:0] ea);
    cpu_u.xfer(ws, a, d, rd, ae);
    chk(rd, exp);
    chk(8'(ae), 8'(ea));
  endtask
  task tick;
    @(posedge ref_clk);
    #5;
  endtask
  task settle;
    tick;
    tick;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    summarize;
  end
  initial
  begin
    {iack_req, module_irq, freeze_req, iack_level, iack_competitor} = '0;
    {rx_start_bit, at_char_boundary, tx_break, fifo_full, char_ready, top_break, top_frame} = '0;
    {top_parity, top_pop, err_reset, output_port_bits, tx_rts_ctrl} = '0;
    repeat (20) tick;
    reset_n = 1'h1;
    foreach (rows[i])
      acc({rows[i][29], 1'h1}, rows[i][28:17], rows[i][16:9], rows[i][8:1], rows[i][0] ? 2'h1 : 2'h2);
    chk(8'(cts_sample_clock_select), 8'h01);
    chk(8'(data_bits_b), 8'h05);
    chk(8'(parity_mode_b), 8'h03);
    chk(8'(status_err_b), 8'h00);
    // multidrop code only with character error mode
    for (int i = 0; i < 4; i++)
    begin
      acc(2'h3, OFF_MODE_A, 8'(i * 9), 8'h00, 2'h2);
      settle;
      chk(8'(data_bits_a), 8'(i + 5));
      chk(8'(parity_mode_a), 8'(i));
    end
    acc(2'h0, OFF_MODE_A, 8'h00, 8'h00, 2'h1);
    acc(2'h2, OFF_MODE_B, 8'h00, 8'h00, 2'h1);
    acc(2'h1, OFF_MODE_B, 8'h00, 8'h3C, 2'h2);
    acc(2'h3, OFF_CFG_LO, 8'h0F, 8'h00, 2'h2);
    acc(2'h0, OFF_MODE_B, 8'h00, 8'h3C, 2'h2);
    acc(2'h0, OFF_VECTOR, 8'h00, 8'h00, 2'h1);
    acc(2'h3, OFF_LEVEL, 8'h03, 8'h00, 2'h2);
    {module_irq, iack_req, iack_level, iack_competitor} = {2'h3, 3'h3, 4'hE};
    settle;
    chk(8'(irq_request_n), 8'h7B);
    chk(iack_vector, 8'hA5);
    iack_competitor = 4'hF;
    settle;
    chk(8'(iack_won), 8'h00);
    // Priority zero keeps out of arbitration
    acc(2'h3, OFF_CFG_LO, 8'h00, 8'h00, 2'h2);
    iack_competitor = 4'h0;
    settle;
    chk(8'(iack_won), 8'h00);
    acc(2'h3, OFF_LEVEL, 8'h00, 8'h00, 2'h2);
    settle;
    chk(8'(irq_request_n), 8'h7F);
    {module_irq, iack_req, freeze_req, at_char_boundary, tx_break} = {3'h1, 2'h3, 2'h2};
    settle;
    chk(8'(chan_frozen), 8'h01);
    acc(2'h3, OFF_CFG_HI, 8'h20, 8'h00, 2'h2);
    settle;
    chk(8'(chan_frozen), 8'h00);
    chk(8'(cts_sample_clock_select), 8'h00);
    freeze_req = 1'h0;
    acc(2'h3, OFF_MODE_A, 8'h80, 8'h00, 2'h2);
    {fifo_full, rx_start_bit} = 4'h5;
    settle;
    chk(8'(rts_n), 8'h03);
    {fifo_full, rx_start_bit} = 4'h0;
    settle;
    chk(8'(rts_n), 8'h02);
    tx_rts_ctrl = 2'h1;
    settle;
    chk(8'(rts_n), 8'h03);
    tx_rts_ctrl = 2'h0;
    acc(2'h3, OFF_MODE_A, 8'h00, 8'h00, 2'h2);
    output_port_bits = 2'h1;
    settle;
    chk(8'(rts_n), 8'h02);
    output_port_bits = 2'h0;
    acc(2'h3, OFF_MODE_A, 8'h40, 8'h00, 2'h2);
    fifo_full = 2'h1;
    settle;
    chk(8'(irq_status_bits), 8'h01);
    acc(2'h3, OFF_MODE_A, 8'h20, 8'h00, 2'h2);
    // Frame error on a character leaving the top
    {fifo_full, top_pop, top_frame} = 6'h05;
    tick;
    {top_pop, top_frame} = 4'h0;
    settle;
    chk(8'(status_err_a), 8'h02);
    err_reset = 2'h1;
    tick;
    err_reset = 2'h0;
    settle;
    chk(8'(status_err_a), 8'h00);
    acc(2'h3, OFF_MODE_A, 8'h00, 8'h00, 2'h2);
    top_break = 2'h1;
    settle;
    chk(8'(status_err_a), 8'h04);
    top_break = 2'h0;
    // Channel B still has tx_break set here before halting
    acc(2'h3, OFF_CFG_HI, 8'h80, 8'h00, 2'h2);
    settle;
    chk(8'(module_clk_en), 8'h00);
    acc(2'h1, OFF_VECTOR, 8'h00, 8'h00, 2'h1);
    acc(2'h1, OFF_CFG_LO, 8'h00, 8'h00, 2'h2);
    soft_reset = 1'h1;
    tick;
    soft_reset = 1'h0;
    acc(2'h1, OFF_CFG_HI, 8'h00, 8'h80, 2'h2);
    acc(2'h3, OFF_CFG_HI, 8'h00, 8'h00, 2'h2);
    settle;
    chk(8'(module_clk_en), 8'h01);
    acc(2'h1, OFF_VECTOR, 8'h00, 8'h0F, 2'h2);
    reset_n = 1'h0;
    settle;
    reset_n = 1'h1;
    acc(2'h1, OFF_CFG_LO, 8'h00, 8'h80, 2'h2);
    summarize;
  end
endmodule
bind dscir_top dscir_monitor mon_u (.*);
